/* File: rtl/gdfp_map.svh */
`ifndef GDFP_MAP_SVH
`define GDFP_MAP_SVH

// Blanking time: tBlank(ns) = 9.13 * Rblank(kohm) + 27, kept in hundredths of ns
`define GDFP_BLANK_SLOPE_CNS    32'd913
`define GDFP_BLANK_OFFSET_CNS   32'd2700
// Default blanking resistor in ohms (gives about 100 ns)
`define GDFP_BLANK_RES_OHM      32'd8060
`define GDFP_CLK_PERIOD_PS      32'd25000
// Blanking resistor upper bound in ohms
`define GDFP_BLANK_RES_MAX_OHM  32'd25000
`define GDFP_BLANK_CNT_W        4
// Short-pulse limit for flag clearing in ns
`define GDFP_SHORT_PULSE_NS     32'd100
`define GDFP_SHORT_PULSE_CYC    ((`GDFP_SHORT_PULSE_NS * 32'd1000) / `GDFP_CLK_PERIOD_PS)

`endif

/* File: rtl/gdfp_pkg.sv */
package gdfp_pkg;

  typedef enum logic [1:0] {
    GDFP_RUN,
    GDFP_HS_FAULT,
    GDFP_OC_FAULT,
    GDFP_SUPPLY_OFF
  } gdfp_state_t;

  typedef struct packed {
    logic pwm;
    logic rectifierEnable;
    logic switchNodeRise;
    logic highSideCompTrip;
    logic overCurrentTrip;
    logic gateSupplyLow;
    logic thermalShutdown;
  } gdfp_in_t;

  typedef struct packed {
    logic highGateDrive;
    logic lowGateDrive;
    logic faultFlag;
  } gdfp_out_t;

endpackage : gdfp_pkg

/* File: rtl/gdfp_blank_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gdfp_map.svh"

module gdfp_blank_timer
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          start,
  input  wire logic [`GDFP_BLANK_CNT_W-1:0]  termCount,
  output logic                               blanking
);

  logic [`GDFP_BLANK_CNT_W-1:0] count_ff;
  logic [`GDFP_BLANK_CNT_W-1:0] nxt_count;
  wire                          running = (count_ff != '0);

  assign nxt_count = start ? termCount : (running ? count_ff - 1'b1 : count_ff);
  assign blanking  = running;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_ff <= '0;
    else
      count_ff <= nxt_count;
  end

endmodule : gdfp_blank_timer

`default_nettype wire

/* File: rtl/gdfp_protect.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gdfp_map.svh"

// Function
// [R1] Switch-node rise starts blanking of high-side comparator
// [R2] Blank ns equals 9.13 times kohm plus 27
// [R3] Pulses shorter than blanking never see high-side faults
// [R4] High-side on, unblanked, comparator trip flags fault
// [R5] Flag low normally, high on fault
// [R6] Four causes: overcurrent, high-side, undervoltage, thermal
// [R7] Overcurrent flag clears at clean pulse falling edge
// [R8] Undervoltage and thermal flag clear automatically
// [R9] Short pulses may need several pulses to clear
// [R10] Thermal shutdown forces both gates low
// [R11] Undervoltage forces both gates low, auto recovers
// [R12] High-side or overcurrent fault kills both gates
// [R13] High-side fault retries on every new pulse
// [R14] Persisting overcurrent suppresses next high-side pulse
// [R15] Overcurrent inhibits switching until current drops
// [R16] Monitor above limit level flags overcurrent
// [R17] Overcurrent comparison held during blanking
// [R18] Thermal and undervoltage outrank overcurrent recovery
// [R19] Blanking is counter with matched terminal count
module gdfp_protect
#(
  parameter int unsigned BLANK_RES_OHM = `GDFP_BLANK_RES_OHM
)
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire gdfp_pkg::gdfp_in_t ctl,
  output gdfp_pkg::gdfp_out_t     drv
);

  localparam int unsigned BlankCns =
    (`GDFP_BLANK_SLOPE_CNS * BLANK_RES_OHM) / 32'd1000 + `GDFP_BLANK_OFFSET_CNS; // R2
  // Least time: round up to whole cycles
  localparam int unsigned BlankCyc =
    (BlankCns * 32'd10 + `GDFP_CLK_PERIOD_PS - 32'd1) / `GDFP_CLK_PERIOD_PS;
  localparam logic [`GDFP_BLANK_CNT_W-1:0] BlankTerm =
    (BlankCyc < 32'd1) ? `GDFP_BLANK_CNT_W'(1) : `GDFP_BLANK_CNT_W'(BlankCyc);

  gdfp_pkg::gdfp_state_t state_ff;
  gdfp_pkg::gdfp_state_t nxt_state;
  logic                  pwm_ff;
  logic                  hiGate_ff;
  logic                  loGate_ff;
  logic                  flag_ff;
  logic                  pulseDirty_ff;
  logic                  nxt_hiGate;
  logic                  nxt_loGate;
  logic                  nxt_flag;
  logic                  nxt_pulseDirty;
  logic                  blanking;
  logic                  blankNow;

  gdfp_blank_timer u_blank
  (
    .clk       (clk),
    .rst       (rst),
    .start     (ctl.switchNodeRise), // R1 R19
    .termCount (BlankTerm),
    .blanking  (blanking)
  );

  // Edge cycle itself is blanked; the counter only loads on it
  assign blankNow  = blanking | ctl.switchNodeRise; // R1

  wire supplyFault = ctl.gateSupplyLow | ctl.thermalShutdown;
  wire pwmRise     = ctl.pwm & ~pwm_ff;
  wire pwmFall     = ~ctl.pwm & pwm_ff;
  // Comparator ignored while blanking; short pulses stay blind
  wire hsTrip      = hiGate_ff & ~blankNow & ctl.highSideCompTrip; // R1 R3 R4
  // Monitor value held through blanking
  wire ocTrip      = ~blankNow & ctl.overCurrentTrip; // R16 R17
  wire anyOcFault  = hsTrip | ocTrip;
  // Fault seen anywhere within this on-time keeps the flag
  wire dirtyNow    = pulseDirty_ff | anyOcFault;

  // Normal synchronous drive with dead time of one cycle
  wire runHi = ctl.pwm & ~loGate_ff;
  wire runLo = ~ctl.pwm & ctl.rectifierEnable & ~hiGate_ff;

  always_comb
  begin
    nxt_state      = state_ff;
    nxt_hiGate     = 1'b0;
    nxt_loGate     = 1'b0;
    nxt_flag       = flag_ff;
    nxt_pulseDirty = ctl.pwm ? dirtyNow : 1'b0;
    if (supplyFault)
    begin
      nxt_state = gdfp_pkg::GDFP_SUPPLY_OFF; // R10 R11 R18
      nxt_flag  = 1'b1; // R5 R6
    end
    else
    begin
      case (state_ff)
        gdfp_pkg::GDFP_RUN:
        begin
          if (ocTrip)
          begin
            nxt_state = gdfp_pkg::GDFP_OC_FAULT; // R12 R14
            nxt_flag  = 1'b1; // R5 R6
          end
          else if (hsTrip)
          begin
            nxt_state = gdfp_pkg::GDFP_HS_FAULT; // R12
            nxt_flag  = 1'b1; // R5 R6
          end
          else
          begin
            nxt_hiGate = runHi;
            nxt_loGate = runLo;
            // Clean on-time ends: clear flag
            if (pwmFall && !dirtyNow)
              nxt_flag = 1'b0; // R7 R9
          end
        end
        gdfp_pkg::GDFP_HS_FAULT:
        begin
          if (ocTrip)
            nxt_state = gdfp_pkg::GDFP_OC_FAULT; // R14
          else if (pwmRise)
          begin
            nxt_state  = gdfp_pkg::GDFP_RUN; // R13
            nxt_hiGate = 1'b1;
          end
          else if (!ctl.pwm && pulseDirty_ff == 1'b0)
            nxt_loGate = 1'b0;
        end
        gdfp_pkg::GDFP_OC_FAULT:
        begin
          // Held off until monitor falls below limit at a pulse start
          if (!ctl.overCurrentTrip && pwmRise)
          begin
            nxt_state  = gdfp_pkg::GDFP_RUN; // R15 R14
            nxt_hiGate = 1'b1;
          end
        end
        gdfp_pkg::GDFP_SUPPLY_OFF:
        begin
          nxt_state = gdfp_pkg::GDFP_RUN;
          nxt_flag  = 1'b0; // R8
        end
        default:
        begin
          nxt_state = gdfp_pkg::GDFP_SUPPLY_OFF;
        end
      endcase
    end
  end

  // Reset behaves like a supply fault until the first clock edge without one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_ff <= gdfp_pkg::GDFP_SUPPLY_OFF;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwm_ff <= 1'b0;
    else
      pwm_ff <= ctl.pwm;
  end

  // Gate drives
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hiGate_ff <= 1'b0;
    else
      hiGate_ff <= nxt_hiGate;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      loGate_ff <= 1'b0;
    else
      loGate_ff <= nxt_loGate;
  end

  // Flag raised during reset, as for a low gate supply
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_ff <= 1'b1;
    else
      flag_ff <= nxt_flag;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pulseDirty_ff <= 1'b0;
    else
      pulseDirty_ff <= nxt_pulseDirty;
  end

  assign drv.highGateDrive = hiGate_ff;
  assign drv.lowGateDrive  = loGate_ff;
  assign drv.faultFlag     = flag_ff;

endmodule : gdfp_protect

`default_nettype wire

/* File: bench/gdfp_protect_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module gdfp_protect_assertions
(
  input wire logic                clk,
  input wire logic                rst,
  input wire gdfp_pkg::gdfp_in_t  ctl,
  input wire gdfp_pkg::gdfp_out_t drv
);
  wire logic hs  = ctl.highSideCompTrip;
  wire logic oc  = ctl.overCurrentTrip;
  wire logic sr  = ctl.switchNodeRise;
  wire logic sup = ctl.gateSupplyLow | ctl.thermalShutdown;
  wire logic fault_flag = drv.faultFlag;
  wire logic hi  = drv.highGateDrive;
  wire logic off = !hi && !drv.lowGateDrive;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_BLANK: assert property (sr && !fault_flag ##0 (!oc && !sup)[*6] |=> !fault_flag)
    else $error("trip in blanking");
  AST_HS_TRIP: assert property ((!sr)[*6] ##0 (hi && hs && !sup) |=> !hi && fault_flag)
    else $error("trip missed");
  AST_THERMAL: assert property (ctl.thermalShutdown |=> off && fault_flag)
    else $error("hot gates on");
  AST_SUPPLY: assert property (ctl.gateSupplyLow |=> off && fault_flag)
    else $error("low supply gates on");
  AST_AUTO_CLR: assert property (($fell(sup) && !oc && !hs) ##1 (!sup && !oc && !hs) |=> !fault_flag)
    else $error("flag stuck");
  AST_OC_FLAG: assert property ((oc && !sr)[*7] |=> fault_flag && !hi)
    else $error("overcurrent missed");
  AST_OC_HOLD: assert property ((oc && !sr)[*8] |=> off)
    else $error("overcurrent switching");
  AST_OC_RISE: assert property ($rose(ctl.pwm) && oc && fault_flag |=> !hi)
    else $error("pulse under overcurrent");
  cover property (fault_flag && $rose(ctl.pwm));
  cover property (sr ##6 hs);
  cover property ($fell(fault_flag));
endmodule : gdfp_protect_assertions
`default_nettype wire

/* File: bench/gdfp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module gdfp_host_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [3:0] onLen,
  output logic            pwm
);
  logic [3:0] cnt_ff;
  // One pulse of onLen cycles per start
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= start ? onLen : cnt_ff - {3'h0, |cnt_ff};
  assign pwm = |cnt_ff;
endmodule : gdfp_host_model
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int BLK = (913 * 8060 / 1000 + 2700 + 2499) / 2500;
  logic                clk = 1'b0;
  logic                rst = 1'b0;
  logic                go = 1'b0;
  logic                pwm;
  logic                prevHi = 1'b0;
  logic                hg = 1'b0;
  logic [3:0]          len = 4'h0;
  logic [5:0]          c = 6'h00;
  int                  miscompares = 0;
  int                  num_checks = 0;
  wire gdfp_pkg::gdfp_in_t ctl = {pwm, c};
  gdfp_pkg::gdfp_out_t drv;
  always #12.5 clk = ~clk;
  gdfp_protect #(.BLANK_RES_OHM(8060)) u_gdfp_protect (.clk(clk), .rst(rst), .ctl(ctl), .drv(drv));
  gdfp_host_model u_gdfp_host_model (.clk(clk), .rst(rst), .start(go), .onLen(len), .pwm(pwm));
  function automatic logic expFlt(input int n, input logic trip);
    return trip && n > BLK + 2;
  endfunction : expFlt
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      c[4] = drv.highGateDrive & ~prevHi;
      prevHi = drv.highGateDrive;
    end
  endtask : step
  task automatic pulse(input int n);
    len = 4'(n);
    go = 1'b1;
    step(1);
    go = 1'b0;
    step(n / 4 + 2);
    hg = drv.highGateDrive;
    step(n + 1);
  endtask : pulse
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    rst = 1'b1;
    void'($urandom(38));
    step(16);
    rst = 1'b0;
    step(4);
    chk(drv, 3'h0);
    repeat (20)
    begin
      c[5] = 1'($urandom);
      pulse(int'($urandom_range(15, 6)));
      chk({hg, drv.lowGateDrive, drv.faultFlag}, {1'b1, c[5], 1'b0});
    end
    c = 6'h08;
    pulse(3);
    chk(drv, {2'h0, expFlt(3, 1'b1)});
    pulse(14);
    chk(drv, {2'h0, expFlt(14, 1'b1)});
    pulse(14);
    chk({1'b0, hg, drv.faultFlag}, 3'h3);
    c = 6'h00;
    pulse(14);
    chk(drv, 3'h0);
    c = 6'h04;
    pulse(14);
    chk(drv, 3'h1);
    pulse(14);
    chk({1'b0, hg, drv.faultFlag}, 3'h1);
    c = 6'h00;
    repeat (4) pulse(3);
    chk(drv, 3'h0);
    for (int i = 0; i < 2; i++)
    begin
      c = 6'h20 | 6'(1 << i);
      pulse(8);
      chk({hg, drv.highGateDrive | drv.lowGateDrive, drv.faultFlag}, 3'h1);
      c = 6'h00;
      step(3);
      chk(drv, 3'h0);
    end
    stop_test;
  end
  initial
  begin
    #100000;
    miscompares++;
    stop_test;
  end
endmodule : tb_top
bind gdfp_protect gdfp_protect_assertions u_gdfp_protect_assertions
  (.clk(clk), .rst(rst), .ctl(ctl), .drv(drv));
`default_nettype wire
